/* File: shu_pkg.sv */
package shu_pkg;

   // Operand buffer geometry and its three regions.
   localparam int SHU_BUF_W = 2048;
   localparam int SHU_WORD_W = 32;
   localparam int SHU_ADDR_W = 6;
   localparam int SHU_MSG_LO = 0;
   localparam int SHU_HASH_LO = 1024;
   localparam int SHU_WORK_LO = 1536;

   // Opcode field position in the instruction word.
   localparam int SHU_OP_LSB = 24;
   localparam logic [7:0] SHU_OP_SHA1 = 8'h69;
   localparam logic [7:0] SHU_OP_S256 = 8'h6A;
   localparam logic [7:0] SHU_OP_S512 = 8'h6B;

   // Index of the last round: 80, 64 and 80 rounds.
   localparam logic [6:0] SHU_LAST_SHA1 = 7'h4F;
   localparam logic [6:0] SHU_LAST_S256 = 7'h3F;
   localparam logic [6:0] SHU_LAST_S512 = 7'h4F;

   // Schedule window length and the SHA-1 phase boundaries.
   localparam logic [6:0] SHU_WIN_LEN = 7'h10;
   localparam logic [6:0] SHU_PH1 = 7'h14;
   localparam logic [6:0] SHU_PH2 = 7'h28;
   localparam logic [6:0] SHU_PH3 = 7'h3C;

   // SHA-1 phase constants.
   localparam logic [31:0] SHU_K1_0 = 32'h5A827999;
   localparam logic [31:0] SHU_K1_1 = 32'h6ED9EBA1;
   localparam logic [31:0] SHU_K1_2 = 32'h8F1BBCDC;
   localparam logic [31:0] SHU_K1_3 = 32'hCA62C1D6;

   // SHA-2 round constants; the 256-bit variant uses the upper halves.
   localparam logic [63:0] SHU_K512 [0:79] = '{
      64'h428A2F98D728AE22, 64'h7137449123EF65CD, 64'hB5C0FBCFEC4D3B2F,
      64'hE9B5DBA58189DBBC, 64'h3956C25BF348B538, 64'h59F111F1B605D019,
      64'h923F82A4AF194F9B, 64'hAB1C5ED5DA6D8118, 64'hD807AA98A3030242,
      64'h12835B0145706FBE, 64'h243185BE4EE4B28C, 64'h550C7DC3D5FFB4E2,
      64'h72BE5D74F27B896F, 64'h80DEB1FE3B1696B1, 64'h9BDC06A725C71235,
      64'hC19BF174CF692694, 64'hE49B69C19EF14AD2, 64'hEFBE4786384F25E3,
      64'h0FC19DC68B8CD5B5, 64'h240CA1CC77AC9C65, 64'h2DE92C6F592B0275,
      64'h4A7484AA6EA6E483, 64'h5CB0A9DCBD41FBD4, 64'h76F988DA831153B5,
      64'h983E5152EE66DFAB, 64'hA831C66D2DB43210, 64'hB00327C898FB213F,
      64'hBF597FC7BEEF0EE4, 64'hC6E00BF33DA88FC2, 64'hD5A79147930AA725,
      64'h06CA6351E003826F, 64'h142929670A0E6E70, 64'h27B70A8546D22FFC,
      64'h2E1B21385C26C926, 64'h4D2C6DFC5AC42AED, 64'h53380D139D95B3DF,
      64'h650A73548BAF63DE, 64'h766A0ABB3C77B2A8, 64'h81C2C92E47EDAEE6,
      64'h92722C851482353B, 64'hA2BFE8A14CF10364, 64'hA81A664BBC423001,
      64'hC24B8B70D0F89791, 64'hC76C51A30654BE30, 64'hD192E819D6EF5218,
      64'hD69906245565A910, 64'hF40E35855771202A, 64'h106AA07032BBD1B8,
      64'h19A4C116B8D2D0C8, 64'h1E376C085141AB53, 64'h2748774CDF8EEB99,
      64'h34B0BCB5E19B48A8, 64'h391C0CB3C5C95A63, 64'h4ED8AA4AE3418ACB,
      64'h5B9CCA4F7763E373, 64'h682E6FF3D6B2B8A3, 64'h748F82EE5DEFB2FC,
      64'h78A5636F43172F60, 64'h84C87814A1F0AB72, 64'h8CC702081A6439EC,
      64'h90BEFFFA23631E28, 64'hA4506CEBDE82BDE9, 64'hBEF9A3F7B2C67915,
      64'hC67178F2E372532B, 64'hCA273ECEEA26619C, 64'hD186B8C721C0C207,
      64'hEADA7DD6CDE0EB1E, 64'hF57D4F7FEE6ED178, 64'h06F067AA72176FBA,
      64'h0A637DC5A2C898A6, 64'h113F9804BEF90DAE, 64'h1B710B35131C471B,
      64'h28DB77F523047D84, 64'h32CAAB7B40C72493, 64'h3C9EBE0A15C9BEBC,
      64'h431D67C49C100D4C, 64'h4CC5D4BECB3E42B6, 64'h597F299CFC657E2A,
      64'h5FCB6FAB3AD6FAEC, 64'h6C44198C4A475817
   };

   // Hash modes selected by the opcode.
   typedef enum logic [1:0] {
      SHU_MODE_SHA1 = 2'h0,
      SHU_MODE_S256 = 2'h1,
      SHU_MODE_S512 = 2'h3
   } shu_mode_t;

   // Unit sequence, Gray coded along idle, load, rounds, finish.
   typedef enum logic [1:0] {
      SHU_ST_IDLE = 2'h0,
      SHU_ST_LOAD = 2'h1,
      SHU_ST_ROUND = 2'h3,
      SHU_ST_FIN = 2'h2
   } shu_state_t;

   // Commands on the host user port.
   typedef enum logic [1:0] {
      SHU_CMD_WRITE = 2'h0,
      SHU_CMD_READ = 2'h1,
      SHU_CMD_ISSUE = 2'h2
   } shu_cmd_t;

endpackage

/* File: shu_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface shu_if;
   import shu_pkg::*;

   // Instruction issue and progress.
   logic instr_valid;
   logic [31:0] instruction_word;
   logic busy;
   logic done;
   // Word access to the operand buffer.
   logic buf_we;
   logic buf_re;
   logic [SHU_ADDR_W-1:0] buf_addr;
   logic [SHU_WORD_W-1:0] buf_wdata;
   logic [SHU_WORD_W-1:0] buf_rdata;
   logic buf_rvalid;

   modport dev (
      input instr_valid, instruction_word, buf_we, buf_re, buf_addr,
      input buf_wdata,
      output busy, done, buf_rdata, buf_rvalid
   );

   modport host (
      output instr_valid, instruction_word, buf_we, buf_re, buf_addr,
      output buf_wdata,
      input busy, done, buf_rdata, buf_rvalid
   );

endinterface

`default_nettype wire

/* File: shu_hash_dev.sv */
`timescale 1ns/1ps
`default_nettype none

module shu_hash_dev
   import shu_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Sequencer and operand buffer side.
   shu_if.dev seq,
   // Observation of progress.
   output logic [6:0] round_idx
);

   function automatic logic [31:0] ror32(input logic [31:0] x,
                                         input int n);
      return (x >> n) | (x << (32 - n));
   endfunction

   function automatic logic [63:0] ror64(input logic [63:0] x,
                                         input int n);
      return (x >> n) | (x << (64 - n));
   endfunction

   shu_state_t st_r;
   shu_mode_t mode_r;
   shu_mode_t op_mode;
   logic op_ok;
   logic accept;
   logic wide;
   logic [6:0] rnd_r;
   logic [6:0] last_rnd;
   logic [SHU_BUF_W-1:0] buf_r;
   logic [3:0] slot;
   logic [63:0] wv [0:15];
   logic [63:0] sv [0:7];
   logic [63:0] nv [0:7];
   logic [63:0] wn;
   logic [63:0] wt;
   logic [63:0] kt;
   logic [31:0] f32;
   logic [31:0] t1a;
   logic [31:0] t2a;
   logic [63:0] t1b;
   logic [63:0] t2b;
   logic done_r;
   logic rvalid_r;
   logic [SHU_WORD_W-1:0] rdata_r;

   // Opcode decode; any other code is simply not taken.
   always_comb
   begin
      op_ok = 1'b1;
      case (seq.instruction_word[SHU_OP_LSB +: 8])
         SHU_OP_SHA1: op_mode = SHU_MODE_SHA1;
         SHU_OP_S256: op_mode = SHU_MODE_S256;
         SHU_OP_S512: op_mode = SHU_MODE_S512;
         default:
         begin
            op_mode = SHU_MODE_SHA1;
            op_ok = 1'b0;
         end
      endcase
   end

   assign accept = seq.instr_valid && op_ok && (st_r == SHU_ST_IDLE);
   assign wide = (mode_r == SHU_MODE_S512);
   assign slot = rnd_r[3:0];
   assign last_rnd = (mode_r == SHU_MODE_S256) ? SHU_LAST_S256 :
                     (wide ? SHU_LAST_S512 : SHU_LAST_SHA1);

   // Buffer words seen at the width of the active mode.
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         wv[i] = wide ? buf_r[SHU_MSG_LO + 64*i +: 64] :
                 {32'h0, buf_r[SHU_MSG_LO + 32*i +: 32]};
      end
      for (int i = 0; i < 8; i++)
      begin
         sv[i] = wide ? buf_r[SHU_WORK_LO + 64*i +: 64] :
                 {32'h0, buf_r[SHU_WORK_LO + 32*i +: 32]};
      end
   end

   // Next schedule word from the 16-word window; the slot it lands in
   // held word t-16, so no separate schedule store is needed.
   always_comb
   begin
      case (mode_r)
         SHU_MODE_SHA1:
            wn = {32'h0, ror32(wv[slot + 4'hD][31:0] ^ wv[slot + 4'h8][31:0]
                 ^ wv[slot + 4'h2][31:0] ^ wv[slot][31:0], 31)};
         SHU_MODE_S256:
            wn = {32'h0,
                  (ror32(wv[slot + 4'hE][31:0], 17)
                   ^ ror32(wv[slot + 4'hE][31:0], 19)
                   ^ (wv[slot + 4'hE][31:0] >> 10))
                  + wv[slot + 4'h9][31:0]
                  + (ror32(wv[slot + 4'h1][31:0], 7)
                   ^ ror32(wv[slot + 4'h1][31:0], 18)
                   ^ (wv[slot + 4'h1][31:0] >> 3))
                  + wv[slot][31:0]};
         default:
            wn = (ror64(wv[slot + 4'hE], 19) ^ ror64(wv[slot + 4'hE], 61)
                  ^ (wv[slot + 4'hE] >> 6)) + wv[slot + 4'h9]
                 + (ror64(wv[slot + 4'h1], 1) ^ ror64(wv[slot + 4'h1], 8)
                  ^ (wv[slot + 4'h1] >> 7)) + wv[slot];
      endcase
      wt = (rnd_r < SHU_WIN_LEN) ? wv[slot] : wn;
   end

   // One compression round per clock on the working copy.
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         nv[i] = sv[i];
      end
      kt = 64'h0;
      f32 = 32'h0;
      t1a = 32'h0;
      t2a = 32'h0;
      t1b = 64'h0;
      t2b = 64'h0;
      case (mode_r)
         SHU_MODE_SHA1:
         begin
            if (rnd_r < SHU_PH1)
            begin
               kt[31:0] = SHU_K1_0;
               f32 = (sv[1][31:0] & sv[2][31:0])
                     | (~sv[1][31:0] & sv[3][31:0]);
            end
            else if (rnd_r >= SHU_PH2 && rnd_r < SHU_PH3)
            begin
               kt[31:0] = SHU_K1_2;
               f32 = (sv[1][31:0] & sv[2][31:0])
                     | (sv[1][31:0] & sv[3][31:0])
                     | (sv[2][31:0] & sv[3][31:0]);
            end
            else
            begin
               kt[31:0] = (rnd_r < SHU_PH2) ? SHU_K1_1 : SHU_K1_3;
               f32 = sv[1][31:0] ^ sv[2][31:0] ^ sv[3][31:0];
            end
            t1a = ror32(sv[0][31:0], 27) + f32 + sv[4][31:0] + kt[31:0]
                  + wt[31:0];
            nv[0] = {32'h0, t1a};
            nv[1] = sv[0];
            nv[2] = {32'h0, ror32(sv[1][31:0], 2)};
            nv[3] = sv[2];
            nv[4] = sv[3];
         end
         SHU_MODE_S256:
         begin
            kt[31:0] = SHU_K512[rnd_r][63:32];
            t1a = sv[7][31:0] + (ror32(sv[4][31:0], 6)
                  ^ ror32(sv[4][31:0], 11) ^ ror32(sv[4][31:0], 25))
                  + ((sv[4][31:0] & sv[5][31:0])
                  | (~sv[4][31:0] & sv[6][31:0])) + kt[31:0]
                  + wt[31:0];
            t2a = (ror32(sv[0][31:0], 2) ^ ror32(sv[0][31:0], 13)
                  ^ ror32(sv[0][31:0], 22))
                  + ((sv[0][31:0] & sv[1][31:0])
                  | (sv[0][31:0] & sv[2][31:0])
                  | (sv[1][31:0] & sv[2][31:0]));
            nv[0] = {32'h0, t1a + t2a};
            nv[4] = {32'h0, sv[3][31:0] + t1a};
            nv[1] = sv[0];
            nv[2] = sv[1];
            nv[3] = sv[2];
            nv[5] = sv[4];
            nv[6] = sv[5];
            nv[7] = sv[6];
         end
         default:
         begin
            kt = SHU_K512[rnd_r];
            t1b = sv[7] + (ror64(sv[4], 14) ^ ror64(sv[4], 18)
                  ^ ror64(sv[4], 41)) + ((sv[4] & sv[5])
                  | (~sv[4] & sv[6])) + kt + wt;
            t2b = (ror64(sv[0], 28) ^ ror64(sv[0], 34) ^ ror64(sv[0], 39))
                  + ((sv[0] & sv[1]) | (sv[0] & sv[2]) | (sv[1] & sv[2]));
            nv[0] = t1b + t2b;
            nv[4] = sv[3] + t1b;
            nv[1] = sv[0];
            nv[2] = sv[1];
            nv[3] = sv[2];
            nv[5] = sv[4];
            nv[6] = sv[5];
            nv[7] = sv[6];
         end
      endcase
   end

   // Sequence: load working copy, run the rounds, fold back, clear.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= SHU_ST_IDLE;
      end
      else
      begin
         case (st_r)
            SHU_ST_IDLE: if (accept) st_r <= SHU_ST_LOAD;
            SHU_ST_LOAD: st_r <= SHU_ST_ROUND;
            SHU_ST_ROUND: if (rnd_r == last_rnd) st_r <= SHU_ST_FIN;
            SHU_ST_FIN: st_r <= SHU_ST_IDLE;
            default: st_r <= SHU_ST_IDLE;
         endcase
      end
   end

   // Mode is captured at acceptance and held for the whole instruction.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_r <= SHU_MODE_SHA1;
      else if (accept)
         mode_r <= op_mode;
   end

   // Round counter restarts for every instruction.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rnd_r <= 7'h0;
      else if (st_r == SHU_ST_ROUND)
         rnd_r <= rnd_r + 7'h1;
      else
         rnd_r <= 7'h0;
   end

   // Operand buffer; the sequencer may only touch it while idle.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_r <= '0;
      end
      else
      begin
         case (st_r)
            SHU_ST_IDLE:
               if (seq.buf_we)
                  buf_r[SHU_WORD_W*seq.buf_addr +: SHU_WORD_W] <= seq.buf_wdata;
            SHU_ST_LOAD:
               buf_r[SHU_BUF_W-1:SHU_WORK_LO] <=
                  buf_r[SHU_WORK_LO-1:SHU_HASH_LO];
            SHU_ST_ROUND:
            begin
               for (int i = 0; i < 8; i++)
               begin
                  if (wide)
                     buf_r[SHU_WORK_LO + 64*i +: 64] <= nv[i];
                  else
                     buf_r[SHU_WORK_LO + 32*i +: 32] <= nv[i][31:0];
               end
               if (wide)
                  buf_r[SHU_MSG_LO + 64*slot +: 64] <= wt;
               else
                  buf_r[SHU_MSG_LO + 32*slot +: 32] <= wt[31:0];
            end
            SHU_ST_FIN:
            begin
               // SHA-1 state is five words; the rest of the region stays.
               for (int i = 0; i < 8; i++)
               begin
                  if (wide)
                     buf_r[SHU_HASH_LO + 64*i +: 64] <=
                        buf_r[SHU_HASH_LO + 64*i +: 64] + sv[i];
                  else if (mode_r == SHU_MODE_S256 || i < 5)
                     buf_r[SHU_HASH_LO + 32*i +: 32] <=
                        buf_r[SHU_HASH_LO + 32*i +: 32] + sv[i][31:0];
               end
               buf_r[SHU_HASH_LO-1:SHU_MSG_LO] <= '0;
            end
            default: ;
         endcase
      end
   end

   // Completion pulse and word reads, served only while idle.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
      end
      else
      begin
         done_r <= (st_r == SHU_ST_FIN);
         rvalid_r <= seq.buf_re && (st_r == SHU_ST_IDLE);
         if (seq.buf_re && (st_r == SHU_ST_IDLE))
            rdata_r <= buf_r[SHU_WORD_W*seq.buf_addr +: SHU_WORD_W];
      end
   end

   assign seq.busy = (st_r != SHU_ST_IDLE);
   assign seq.done = done_r;
   assign seq.buf_rvalid = rvalid_r;
   assign seq.buf_rdata = rdata_r;
   assign round_idx = rnd_r;

endmodule // shu_hash_dev

`default_nettype wire

/* File: shu_seq_host.sv */
`timescale 1ns/1ps
`default_nettype none

module shu_seq_host
   import shu_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Link to the hash unit.
   shu_if.host seq,
   // User command port.
   input wire logic usr_cmd_valid,
   output logic usr_cmd_ready,
   input wire logic [1:0] usr_cmd_kind,
   input wire logic [SHU_ADDR_W-1:0] usr_addr,
   input wire logic [SHU_WORD_W-1:0] usr_wdata,
   input wire logic [7:0] usr_opcode,
   // User results.
   output logic [SHU_WORD_W-1:0] usr_rdata,
   output logic usr_rvalid,
   output logic usr_done
);

   logic take;
   logic iv_r;
   logic [31:0] iw_r;
   logic we_r;
   logic re_r;
   logic [SHU_ADDR_W-1:0] addr_r;
   logic [SHU_WORD_W-1:0] wdata_r;
   logic [SHU_WORD_W-1:0] rdata_r;
   logic rvalid_r;
   logic done_r;

   // An issued instruction blocks the port for one cycle because the
   // unit only raises busy on the edge after it takes the opcode.
   assign usr_cmd_ready = !seq.busy && !iv_r;
   assign take = usr_cmd_valid && usr_cmd_ready;

   // Each command becomes a one-cycle request on the link.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         iv_r <= 1'b0;
         we_r <= 1'b0;
         re_r <= 1'b0;
      end
      else
      begin
         iv_r <= take && (usr_cmd_kind == SHU_CMD_ISSUE);
         we_r <= take && (usr_cmd_kind == SHU_CMD_WRITE);
         re_r <= take && (usr_cmd_kind == SHU_CMD_READ);
      end
   end

   // Request payload, held until the next command replaces it.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         iw_r <= 32'h0;
         addr_r <= '0;
         wdata_r <= 32'h0;
      end
      else if (take)
      begin
         iw_r <= {usr_opcode, 24'h0};
         addr_r <= usr_addr;
         wdata_r <= usr_wdata;
      end
   end

   // Results are registered once more toward the user.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_r <= 32'h0;
         rvalid_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         rvalid_r <= seq.buf_rvalid;
         done_r <= seq.done;
         if (seq.buf_rvalid)
            rdata_r <= seq.buf_rdata;
      end
   end

   assign seq.instr_valid = iv_r;
   assign seq.instruction_word = iw_r;
   assign seq.buf_we = we_r;
   assign seq.buf_re = re_r;
   assign seq.buf_addr = addr_r;
   assign seq.buf_wdata = wdata_r;
   assign usr_rdata = rdata_r;
   assign usr_rvalid = rvalid_r;
   assign usr_done = done_r;

endmodule // shu_seq_host

`default_nettype wire

/* File: shu_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module shu_monitor
   import shu_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Instruction link.
   input wire logic instr_valid,
   input wire logic [31:0] instruction_word,
   input wire logic busy,
   input wire logic done,
   // Buffer read path.
   input wire logic buf_re,
   input wire logic buf_rvalid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic [7:0] op;
   logic take;
   logic [6:0] cnt_r;
   logic [6:0] exp_r;

   // Only an idle unit with a known opcode takes an instruction.
   assign op = instruction_word[31:24];
   assign take = instr_valid && !busy && (op == SHU_OP_SHA1 ||
      op == SHU_OP_S256 || op == SHU_OP_S512);

   // Consecutive busy cycles; restarts whenever busy is low.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= 7'h00;
      else
         cnt_r <= busy ? cnt_r + 7'h01 : 7'h00;
   end

   // Expected busy length, latched at the accept so a later opcode cannot
   // disturb it.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         exp_r <= 7'h00;
      else if (take)
         exp_r <= (op == SHU_OP_S256) ? 7'h42 : 7'h52;
   end

   AST_BUSY_START: assert property (take |=> busy)
      else $error("busy did not rise after an accepted instruction");
   AST_SHA1_DONE: assert property (take && op == SHU_OP_SHA1 |-> ##83 done)
      else $error("160-bit hash did not finish after 80 rounds");
   AST_S256_DONE: assert property (take && op == SHU_OP_S256 |-> ##67 done)
      else $error("256-bit state hash did not finish after 64 rounds");
   AST_S512_DONE: assert property (take && op == SHU_OP_S512 |-> ##83 done)
      else $error("512-bit state hash did not finish after 80 rounds");
   AST_BUSY_LEN: assert property ($fell(busy) |-> cnt_r == exp_r && done)
      else $error("busy length does not match the round count");
   AST_DONE_END: assert property (done |-> !busy && $past(busy))
      else $error("done not aligned with the end of busy");
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done lasted more than one cycle");
   AST_BAD_OP: assert property (instr_valid && !busy && !take |=> !busy)
      else $error("unknown opcode started the unit");
   AST_RD_REFUSE: assert property (buf_rvalid |-> $past(buf_re) && !$past(busy))
      else $error("read answered without an idle read request");
endmodule // shu_monitor

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import shu_pkg::*;
;
   // Ceiling well above the roughly 1000 cycles the sequence needs.
   localparam int LIMIT = 20000;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic usr_cmd_valid = 1'b0;
   logic usr_cmd_ready;
   logic [1:0] usr_cmd_kind = 2'h3;
   logic [SHU_ADDR_W-1:0] usr_addr = 6'h00;
   logic [SHU_WORD_W-1:0] usr_wdata = 32'h00000000;
   logic [7:0] usr_opcode = 8'h00;
   logic [SHU_WORD_W-1:0] usr_rdata;
   logic usr_rvalid;
   logic usr_done;
   logic [6:0] round_idx;
   int fails = 0;
   int checked = 0;
   int cyc = 0;

   // Standard initial chaining values and expected digests; the 256-bit
   // initial value is the upper half of each 64-bit one.
   logic [31:0] iv1 [5] = '{32'h67452301, 32'hEFCDAB89, 32'h98BADCFE,
      32'h10325476, 32'hC3D2E1F0};
   logic [31:0] dg1 [5] = '{32'hA9993E36, 32'h4706816A, 32'hBA3E2571,
      32'h7850C26C, 32'h9CD0D89D};
   logic [31:0] dg2 [8] = '{32'h248D6A61, 32'hD20638B8, 32'hE5C02693,
      32'h0C3E6039, 32'hA33CE459, 32'h64FF2167, 32'hF6ECEDD4, 32'h19DB06C1};
   logic [63:0] iv5 [8] = '{64'h6A09E667F3BCC908, 64'hBB67AE8584CAA73B,
      64'h3C6EF372FE94F82B, 64'hA54FF53A5F1D36F1, 64'h510E527FADE682D1,
      64'h9B05688C2B3E6C1F, 64'h1F83D9ABFB41BD6B, 64'h5BE0CD19137E2179};
   logic [63:0] dg5 [8] = '{64'hDDAF35A193617ABA, 64'hCC417349AE204131,
      64'h12E6FA4E89A97EA2, 64'h0A9EEEE64B55D39A, 64'h2192992A274FC1A8,
      64'h36BA3C23A3FEEBBD, 64'h454D4423643CE80E, 64'h2A9AC94FA54CA49F};

   always #50 core_clk = ~core_clk;

   // The two ends joined across the link, with the checker beside it.
   shu_if lnk ();
   shu_hash_dev i_shu_hash_dev (.core_clk(core_clk), .rst_n(rst_n),
      .seq(lnk), .round_idx(round_idx));
   shu_seq_host i_shu_seq_host (.core_clk(core_clk), .rst_n(rst_n),
      .seq(lnk), .usr_cmd_valid(usr_cmd_valid),
      .usr_cmd_ready(usr_cmd_ready), .usr_cmd_kind(usr_cmd_kind),
      .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_opcode(usr_opcode),
      .usr_rdata(usr_rdata), .usr_rvalid(usr_rvalid), .usr_done(usr_done));
   shu_monitor i_shu_monitor (.core_clk(core_clk), .rst_n(rst_n),
      .instr_valid(lnk.instr_valid), .instruction_word(lnk.instruction_word),
      .busy(lnk.busy), .done(lnk.done), .buf_re(lnk.buf_re),
      .buf_rvalid(lnk.buf_rvalid));

   // Prints the verdict and stops; shared by the sequence and the timeout.
   task automatic complete_run();
   begin
      if (fails == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask

   // Word comparison with case equality, so unknowns never match.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask

   // One user command, held until the host takes it.
   task automatic cmd(input shu_cmd_t k, input logic [5:0] a,
      input logic [31:0] d, input logic [7:0] op);
      logic r;
   begin
      @(posedge core_clk);
      usr_cmd_valid <= 1'b1;
      usr_cmd_kind <= k;
      usr_addr <= a;
      usr_wdata <= d;
      usr_opcode <= op;
      r = 1'b0;
      for (int i = 0; i < 300 && !r; i++)
      begin
         @(negedge core_clk);
         r = (usr_cmd_ready === 1'b1);
         @(posedge core_clk);
      end
      chk({31'h00000000, r}, 32'h00000001);
      usr_cmd_valid <= 1'b0;
      usr_cmd_kind <= 2'h3;
   end
   endtask

   // Reads one buffer word; a missing answer leaves an unknown behind.
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] got;
   begin
      got = 'x;
      cmd(SHU_CMD_READ, a, 32'h00000000, 8'h00);
      for (int i = 0; i < 8 && usr_rvalid !== 1'b1; i++)
         @(negedge core_clk);
      if (usr_rvalid === 1'b1)
         got = usr_rdata;
      chk(got, exp);
   end
   endtask

   // Issues an opcode and watches the link word, rounds and completion.
   // In the closing cycle the round counter shows the round count itself.
   task automatic issue(input logic [7:0] op, input logic [6:0] last,
      input logic seen_exp);
      logic seen;
      logic [6:0] rmax;
   begin
      seen = 1'b0;
      rmax = 7'h00;
      cmd(SHU_CMD_ISSUE, 6'h00, 32'h00000000, op);
      for (int i = 0; i < 120 && !seen; i++)
      begin
         @(negedge core_clk);
         if (lnk.instr_valid === 1'b1)
            chk(lnk.instruction_word, {op, 24'h000000});
         if (round_idx > rmax)
            rmax = round_idx;
         seen = (usr_done === 1'b1);
      end
      chk({31'h00000000, seen}, {31'h00000000, seen_exp});
      chk({25'h0000000, rmax}, {25'h0000000, last});
   end
   endtask

   // Cuts a hang short.
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         fails++;
         complete_run();
      end
   end

   // Main sequence: three hash kinds, chaining, clearing, a bad opcode.
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk(6'h20, 32'h00000000);
      for (int i = 0; i < 5; i++)
         cmd(SHU_CMD_WRITE, 6'(32 + i), iv1[i], 8'h00);
      cmd(SHU_CMD_WRITE, 6'h00, 32'h61626380, 8'h00);
      cmd(SHU_CMD_WRITE, 6'h0F, 32'h00000018, 8'h00);
      issue(SHU_OP_SHA1, 7'h50, 1'b1);
      for (int i = 0; i < 5; i++)
         rd_chk(6'(32 + i), dg1[i]);
      for (int i = 0; i < 16; i++)
         rd_chk(6'(i), 32'h00000000);
      for (int i = 0; i < 8; i++)
         cmd(SHU_CMD_WRITE, 6'(32 + i), iv5[i][63:32], 8'h00);
      for (int i = 0; i < 14; i++)
         cmd(SHU_CMD_WRITE, 6'(i), 32'h61626364 + i * 32'h01010101,
            8'h00);
      cmd(SHU_CMD_WRITE, 6'h0E, 32'h80000000, 8'h00);
      issue(SHU_OP_S256, 7'h40, 1'b1);
      cmd(SHU_CMD_WRITE, 6'h0F, 32'h000001C0, 8'h00);
      issue(SHU_OP_S256, 7'h40, 1'b1);
      for (int i = 0; i < 8; i++)
         rd_chk(6'(32 + i), dg2[i]);
      rd_chk(6'h28, 32'h00000000);
      for (int j = 0; j < 16; j++)
         cmd(SHU_CMD_WRITE, 6'(32 + j),
            j[0] ? iv5[j / 2][63:32] : iv5[j / 2][31:0], 8'h00);
      cmd(SHU_CMD_WRITE, 6'h01, 32'h61626380, 8'h00);
      cmd(SHU_CMD_WRITE, 6'h1E, 32'h00000018, 8'h00);
      issue(SHU_OP_S512, 7'h50, 1'b1);
      for (int j = 0; j < 16; j++)
         rd_chk(6'(32 + j),
            j[0] ? dg5[j / 2][63:32] : dg5[j / 2][31:0]);
      for (int i = 0; i < 32; i++)
         rd_chk(6'(i), 32'h00000000);
      issue(8'h6C, 7'h00, 1'b0);
      rd_chk(6'h20, dg5[0][31:0]);
      complete_run();
   end
endmodule // tb_top

`default_nettype wire
